// >>> logic/tse_top.sv
// Trigger delay, pulse scaling and shutter exposure control
//
// What this block does
// RL1: Delay each accepted trigger by programmed count.
// RL2: Raw and microsecond trigger delay stay consistent.
// RL3: Divider passes one trigger per group.
// RL4: Multiplier with divider sets accepted trigger ratio.
// RL5: Policy off keeps the shutter open.
// RL6: Timed policy opens at frame start, times out.
// RL7: Pulse length, rising/high sense: open while high.
// RL8: Pulse length, falling/low sense: open while low.
// RL9: Separate policy uses dedicated exposure triggers.
// RL10: Exposure triggers ignored outside separate policy.
// RL11: Gate trigger high: expose for its pulse.
// RL12: Open on start edge, close on end edge.
// RL13: Exposure time settable in microseconds.
// RL14: Exposure time settable in raw count.
// RL15: Raw and microsecond exposure time stay consistent.
// RL16: Auto exposure acts only in timed policy.
// RL17: Auto off uses the programmed exposure only.
// RL18: Auto once converges then returns to off.
// RL19: Auto continuous keeps adapting while selected.
// RL20: Trigger valid by selected edge or level.
// RL21: Trigger delay settable in microseconds.
// RL22: Unity scaling, zero delay: trigger next cycle.
`include "tse_regs.svh"

module tse_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire tse_pkg::tse_bus_req_t bus,
  output logic [31:0] rdata,
  // Trigger and exposure lines
  input wire tse_pkg::tse_lines_t lines,
  input wire logic frame_begin_evt,
  // Brightness meter for automatic exposure
  input wire logic meter_valid,
  input wire logic [7:0] meter_level,
  // Outputs
  output logic trig_out,
  output logic shutter_open
);

  localparam logic [27:0] RAW_CYC = 28'(`TSE_RAW_CYC);
  localparam logic [23:0] RAW_PER_US = 24'(`TSE_RAW_PER_US);

  tse_pkg::tse_state_t s;
  tse_pkg::tse_state_t next_s;
  logic valid;
  logic fire;
  logic open_edge;
  logic close_edge;
  logic [15:0] div_eff;
  logic [19:0] sum;
  logic [8:0] lo_bound;
  logic [8:0] hi_bound;
  logic [24:0] grown;

  always_comb begin
    next_s = s;
    valid = 1'b0;
    fire = 1'b0;
    next_s.rdata = 32'h0;
    next_s.prev_frame = lines.frame_trig;
    next_s.prev_open = lines.open_trig;
    next_s.prev_close = lines.close_trig;

    // Trigger qualification; a level counts once, at the start of its period
    unique case (s.sense)
      tse_pkg::edge_up: valid = lines.frame_trig & ~s.prev_frame; // [RL20]
      tse_pkg::edge_down: valid = ~lines.frame_trig & s.prev_frame; // [RL20]
      tse_pkg::edge_any: valid = lines.frame_trig ^ s.prev_frame; // [RL20]
      tse_pkg::level_one: valid = lines.frame_trig & ~s.prev_frame; // [RL20]
      tse_pkg::level_zero: valid = ~lines.frame_trig & s.prev_frame; // [RL20]
      default: valid = 1'b0;
    endcase

    // One trigger in flight; triggers arriving during a delay are dropped
    if (s.hold_busy) begin
      next_s.hold_left = s.hold_left - 28'h1;
      if (s.hold_left == 28'h1) begin
        fire = 1'b1; // [RL1]
        next_s.hold_busy = 1'b0;
      end
    end else if (valid) begin
      if (s.hold_count == 24'h0) begin
        fire = 1'b1; // [RL22]
      end else begin
        next_s.hold_busy = 1'b1;
        next_s.hold_left = 28'(s.hold_count) * RAW_CYC; // [RL1]
      end
    end

    // Credit scaler: each trigger adds mul, each output spends div
    div_eff = (s.div == 16'h0) ? 16'h1 : s.div;
    sum = s.credit + (fire ? 20'(s.mul) : 20'h0); // [RL4]
    if (sum >= 20'(div_eff)) begin
      next_s.trig_out = 1'b1; // [RL3]
      next_s.credit = sum - 20'(div_eff);
    end else begin
      next_s.trig_out = 1'b0;
      next_s.credit = sum;
    end

    open_edge = s.open_fall ? (~lines.open_trig & s.prev_open)
                            : (lines.open_trig & ~s.prev_open);
    close_edge = s.close_fall ? (~lines.close_trig & s.prev_close)
                              : (lines.close_trig & ~s.prev_close);

    // Only the branch of the selected policy looks at its own inputs
    unique case (s.policy)
      tse_pkg::policy_off: begin
        next_s.shutter_open = 1'b1; // [RL5]
        next_s.exp_left = 28'h0;
      end
      tse_pkg::policy_timed: begin
        if (frame_begin_evt && s.shut_count != 24'h0) begin
          next_s.shutter_open = 1'b1; // [RL6]
          next_s.exp_left = 28'(s.shut_count) * RAW_CYC; // [RL14]
        end else if (s.exp_left > 28'h1) begin
          next_s.exp_left = s.exp_left - 28'h1;
        end else begin
          next_s.exp_left = 28'h0;
          next_s.shutter_open = 1'b0; // [RL6] [RL10]
        end
      end
      tse_pkg::pulse_length_driven: begin
        next_s.exp_left = 28'h0;
        if (s.sense == tse_pkg::edge_down || s.sense == tse_pkg::level_zero)
        begin
          next_s.shutter_open = ~lines.frame_trig; // [RL8]
        end else begin
          next_s.shutter_open = lines.frame_trig; // [RL7]
        end
      end
      tse_pkg::separate_trig_driven: begin
        next_s.exp_left = 28'h0;
        if (s.gate_en) begin
          next_s.shutter_open = lines.gate_trig ^ s.gate_low; // [RL9] [RL11]
        end else if (close_edge) begin
          next_s.shutter_open = 1'b0; // [RL12]
        end else if (open_edge) begin
          next_s.shutter_open = 1'b1; // [RL12]
        end
      end
    endcase

    // Simple step search toward a target brightness window
    lo_bound = 9'(meter_level) + 9'(s.tol);
    hi_bound = 9'(s.target) + 9'(s.tol);
    grown = 25'(s.shut_count) + 25'(s.step);
    if (s.policy == tse_pkg::policy_timed &&
        s.auto_sel != tse_pkg::auto_off && meter_valid) begin // [RL16] [RL17]
      next_s.converged = 1'b0;
      if (lo_bound < 9'(s.target)) begin
        next_s.shut_count = grown[24] ? 24'hffffff : grown[23:0]; // [RL19]
      end else if (9'(meter_level) > hi_bound) begin
        next_s.shut_count = (s.shut_count > 24'(s.step)) ?
                            s.shut_count - 24'(s.step) : 24'h0; // [RL19]
      end else begin
        next_s.converged = 1'b1;
        if (s.auto_sel == tse_pkg::auto_once) begin
          next_s.auto_sel = tse_pkg::auto_off; // [RL18]
        end
      end
    end

    // A software write lands after the auto step, so it wins the cycle
    if (bus.wr) begin
      unique case (bus.addr)
        `TSE_ADDR_CTRL: begin
          next_s.policy = tse_pkg::tse_policy_t'(
            bus.wdata[`TSE_CTRL_POLICY_LSB +: 2]);
          next_s.sense = tse_pkg::tse_sense_t'(
            bus.wdata[`TSE_CTRL_SENSE_LSB +: 3]);
          next_s.auto_sel = tse_pkg::tse_auto_t'(
            bus.wdata[`TSE_CTRL_AUTO_LSB +: 2]);
          next_s.gate_en = bus.wdata[`TSE_CTRL_GATE_EN];
          next_s.gate_low = bus.wdata[`TSE_CTRL_GATE_LOW];
          next_s.open_fall = bus.wdata[`TSE_CTRL_OPEN_FALL];
          next_s.close_fall = bus.wdata[`TSE_CTRL_CLOSE_FALL];
        end
        `TSE_ADDR_HOLD_CNT: next_s.hold_count = bus.wdata[23:0];
        `TSE_ADDR_HOLD_US, `TSE_ADDR_HOLD_US_LEG:
          next_s.hold_count = bus.wdata[23:0] * RAW_PER_US; // [RL2] [RL21]
        `TSE_ADDR_SHUT_CNT: next_s.shut_count = bus.wdata[23:0]; // [RL14]
        `TSE_ADDR_SHUT_US, `TSE_ADDR_SHUT_US_LEG:
          next_s.shut_count = bus.wdata[23:0] * RAW_PER_US; // [RL13] [RL15]
        `TSE_ADDR_DIV: next_s.div = bus.wdata[15:0];
        `TSE_ADDR_MUL: next_s.mul = bus.wdata[15:0];
        `TSE_ADDR_AUTO: begin
          next_s.target = bus.wdata[`TSE_AUTO_TARGET_LSB +: 8];
          next_s.tol = bus.wdata[`TSE_AUTO_TOL_LSB +: 8];
          next_s.step = bus.wdata[`TSE_AUTO_STEP_LSB +: 16];
        end
        default: ;
      endcase
    end

    // Microsecond views are derived from the raw count, so they cannot drift
    if (bus.rd) begin
      unique case (bus.addr)
        `TSE_ADDR_CTRL:
          next_s.rdata = {21'h0, s.close_fall, s.open_fall, s.gate_low,
                          s.gate_en, s.auto_sel, s.sense, s.policy};
        `TSE_ADDR_HOLD_CNT: next_s.rdata = 32'(s.hold_count);
        `TSE_ADDR_HOLD_US, `TSE_ADDR_HOLD_US_LEG:
          next_s.rdata = 32'(s.hold_count / RAW_PER_US); // [RL2]
        `TSE_ADDR_SHUT_CNT: next_s.rdata = 32'(s.shut_count);
        `TSE_ADDR_SHUT_US, `TSE_ADDR_SHUT_US_LEG:
          next_s.rdata = 32'(s.shut_count / RAW_PER_US); // [RL15]
        `TSE_ADDR_DIV: next_s.rdata = 32'(s.div);
        `TSE_ADDR_MUL: next_s.rdata = 32'(s.mul);
        `TSE_ADDR_AUTO: next_s.rdata = {s.step, s.tol, s.target};
        `TSE_ADDR_STATUS:
          next_s.rdata = {28'h0, s.converged, s.hold_busy,
                          s.shutter_open, s.trig_out};
        default: next_s.rdata = 32'h0;
      endcase
    end

    if (reset) begin
      next_s = tse_pkg::tse_state_t'('0);
      next_s.div = `TSE_DIV_RST;
      next_s.mul = `TSE_MUL_RST;
      next_s.target = `TSE_TARGET_RST;
      next_s.tol = `TSE_TOL_RST;
      next_s.step = `TSE_STEP_RST;
    end
  end

  always_ff @(posedge mclk) begin
    s <= next_s;
  end

  assign rdata = s.rdata;
  assign trig_out = s.trig_out;
  assign shutter_open = s.shutter_open;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence unity_path;
    s.div == 16'h1 && s.mul == 16'h1 && s.credit == 20'h0 &&
    s.hold_count == 24'h0 && !s.hold_busy && valid;
  endsequence

  sequence armed_one_unit;
    valid && !s.hold_busy && s.hold_count == 24'h1;
  endsequence

  unity_pass_a: assert property (unity_path |=> s.trig_out) // [RL22]
    else $error("unity trigger did not pass next cycle");

  hold_time_a: assert property (armed_one_unit |-> ##10 fire) // [RL1]
    else $error("trigger delay of one unit not ten cycles");

  div_drop_a: assert property ( // [RL3]
    (s.div == 16'h2 && s.mul == 16'h1 && s.credit == 20'h0 && fire)
    |=> !s.trig_out)
    else $error("divider passed the first trigger of a pair");

  policy_off_a: assert property ( // [RL5]
    s.policy == tse_pkg::policy_off |=> s.shutter_open)
    else $error("shutter closed while policy off");

  timed_load_a: assert property ( // [RL6]
    (s.policy == tse_pkg::policy_timed && frame_begin_evt &&
     s.shut_count != 24'h0)
    |=> s.shutter_open && s.exp_left == 28'($past(s.shut_count)) * RAW_CYC)
    else $error("timed exposure did not start with frame");

  timed_end_a: assert property ( // [RL10]
    (s.policy == tse_pkg::policy_timed && s.exp_left <= 28'h1 &&
     !frame_begin_evt) |=> !s.shutter_open)
    else $error("timed exposure stayed open past its end");

  width_high_a: assert property ( // [RL7]
    (s.policy == tse_pkg::pulse_length_driven &&
     (s.sense == tse_pkg::edge_up || s.sense == tse_pkg::level_one))
    |=> s.shutter_open == $past(lines.frame_trig))
    else $error("shutter does not follow high trigger");

  width_low_a: assert property ( // [RL8]
    (s.policy == tse_pkg::pulse_length_driven &&
     s.sense == tse_pkg::edge_down)
    |=> s.shutter_open != $past(lines.frame_trig))
    else $error("shutter does not follow low trigger");

  gate_follow_a: assert property ( // [RL11]
    (s.policy == tse_pkg::separate_trig_driven && s.gate_en && !s.gate_low)
    |=> s.shutter_open == $past(lines.gate_trig))
    else $error("shutter does not follow gate trigger");

  close_edge_a: assert property ( // [RL12]
    (s.policy == tse_pkg::separate_trig_driven && !s.gate_en && close_edge)
    |=> !s.shutter_open)
    else $error("shutter not closed on end edge");

  auto_once_a: assert property ( // [RL18]
    (s.policy == tse_pkg::policy_timed && s.auto_sel == tse_pkg::auto_once &&
     meter_valid && !bus.wr && lo_bound >= 9'(s.target) &&
     9'(meter_level) <= hi_bound) |=> s.auto_sel == tse_pkg::auto_off)
    else $error("single auto exposure did not return to off");

  hold_view_a: assert property ( // [RL2]
    (bus.rd && bus.addr == `TSE_ADDR_HOLD_US && !reset)
    |=> s.rdata == 32'($past(s.hold_count) / RAW_PER_US))
    else $error("microsecond delay view disagrees with count");

endmodule

// >>> logic/tse_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef TSE_REGS_SVH
`define TSE_REGS_SVH

`define TSE_ADDR_CTRL 8'h00
`define TSE_ADDR_HOLD_CNT 8'h04
`define TSE_ADDR_HOLD_US 8'h08
`define TSE_ADDR_HOLD_US_LEG 8'h0c
`define TSE_ADDR_SHUT_CNT 8'h10
`define TSE_ADDR_SHUT_US 8'h14
`define TSE_ADDR_SHUT_US_LEG 8'h18
`define TSE_ADDR_DIV 8'h1c
`define TSE_ADDR_MUL 8'h20
`define TSE_ADDR_AUTO 8'h24
`define TSE_ADDR_STATUS 8'h28

`define TSE_CTRL_POLICY_LSB 0
`define TSE_CTRL_SENSE_LSB 2
`define TSE_CTRL_AUTO_LSB 5
`define TSE_CTRL_GATE_EN 7
`define TSE_CTRL_GATE_LOW 8
`define TSE_CTRL_OPEN_FALL 9
`define TSE_CTRL_CLOSE_FALL 10

`define TSE_AUTO_TARGET_LSB 0
`define TSE_AUTO_TOL_LSB 8
`define TSE_AUTO_STEP_LSB 16

`define TSE_DIV_RST 16'h0001
`define TSE_MUL_RST 16'h0001
`define TSE_TARGET_RST 8'h80
`define TSE_TOL_RST 8'h08
`define TSE_STEP_RST 16'h000a

`define TSE_CLK_MHZ 100
`define TSE_RAW_NS 100
`define TSE_RAW_CYC ((`TSE_RAW_NS * `TSE_CLK_MHZ) / 1000)
`define TSE_RAW_PER_US (1000 / `TSE_RAW_NS)

`endif

// >>> logic/tse_pkg.sv
// Types shared by the trigger scaling and exposure control block
package tse_pkg;

  typedef enum logic [1:0] {
    policy_off,
    policy_timed,
    pulse_length_driven,
    separate_trig_driven
  } tse_policy_t;

  typedef enum logic [2:0] {
    edge_up,
    edge_down,
    edge_any,
    level_one,
    level_zero
  } tse_sense_t;

  typedef enum logic [1:0] {
    auto_off,
    auto_once,
    auto_cont
  } tse_auto_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tse_bus_req_t;

  typedef struct packed {
    logic frame_trig;
    logic open_trig;
    logic close_trig;
    logic gate_trig;
  } tse_lines_t;

  typedef struct packed {
    tse_policy_t policy;
    tse_sense_t sense;
    tse_auto_t auto_sel;
    logic gate_en;
    logic gate_low;
    logic open_fall;
    logic close_fall;
    logic [23:0] hold_count;
    logic [23:0] shut_count;
    logic [15:0] div;
    logic [15:0] mul;
    logic [7:0] target;
    logic [7:0] tol;
    logic [15:0] step;
    logic prev_frame;
    logic prev_open;
    logic prev_close;
    logic hold_busy;
    logic [27:0] hold_left;
    logic [19:0] credit;
    logic [27:0] exp_left;
    logic converged;
    logic trig_out;
    logic shutter_open;
    logic [31:0] rdata;
  } tse_state_t;

endpackage

// >>> dv/tse_far_model.sv
// Far-side model: trigger lines, frame start event and brightness meter
module tse_far_model (
  // Clock
  input wire logic mclk,
  // Toward the block
  output tse_pkg::tse_lines_t lines,
  output logic frame_begin_evt,
  output logic meter_valid,
  output logic [7:0] meter_level
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    lines = '0;
    frame_begin_evt = 1'b0;
    meter_valid = 1'b0;
    meter_level = 8'h5a;
  end

  // Lines move just after an edge, like a synchronous source
  task automatic drive(input logic [3:0] v);
    @(posedge mclk);
    lines <= v;
  endtask

  task automatic frame_start();
    @(posedge mclk);
    frame_begin_evt <= 1'b1;
    @(posedge mclk);
    frame_begin_evt <= 1'b0;
  endtask

  // Level means nothing without the strobe, so it is scrambled after it
  task automatic meter(input logic [7:0] lvl);
    @(posedge mclk);
    meter_valid <= 1'b1;
    meter_level <= lvl;
    @(posedge mclk);
    meter_valid <= 1'b0;
    meter_level <= ~lvl;
  endtask
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for trigger scaling and exposure control
`include "tse_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk;
  logic reset;
  tse_pkg::tse_bus_req_t bus;
  logic [31:0] rdata;
  tse_pkg::tse_lines_t lines;
  logic frame_begin_evt;
  logic meter_valid;
  logic [7:0] meter_level;
  logic trig_out;
  logic shutter_open;
  int bad_count = 0;
  int num_checks = 0;
  int trig_seen = 0;
  int n;
  int sense_exp[5] = '{1, 1, 2, 1, 1};
  int dtab[3] = '{2, 1, 3};
  int mtab[3] = '{1, 2, 2};
  int ptab[3] = '{4, 1, 3};

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  tse_top u_dut (
    .mclk(mclk),
    .reset(reset),
    .bus(bus),
    .rdata(rdata),
    .lines(lines),
    .frame_begin_evt(frame_begin_evt),
    .meter_valid(meter_valid),
    .meter_level(meter_level),
    .trig_out(trig_out),
    .shutter_open(shutter_open)
  );

  tse_far_model u_far (
    .mclk(mclk),
    .lines(lines),
    .frame_begin_evt(frame_begin_evt),
    .meter_valid(meter_valid),
    .meter_level(meter_level)
  );

  always @(posedge mclk) begin
    if (trig_out === 1'b1) begin
      trig_seen <= trig_seen + 1;
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s: got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tmo(input int k);
    if (k >= 500) begin
      bad_count++;
      $display("[ERR] %0t wait expired", $time);
      wrap_up();
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp, "register read");
  endtask

  task automatic lvl(input logic [3:0] v, input int k, input logic exp);
    u_far.drive(v);
    cyc(k);
    #1;
    chk({31'h0, shutter_open}, {31'h0, exp}, "shutter level");
  endtask

  task automatic latency(input int exp);
    u_far.drive(4'b1000);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
      tmo(n);
    end while (trig_out !== 1'b1);
    chk(32'(n), 32'(exp), "trigger latency");
    u_far.drive(4'b0000);
    // Let the pulse counter settle before a caller samples it
    #1;
  endtask

  task automatic pulses(input int k);
    repeat (k) begin
      u_far.drive(4'b1000);
      u_far.drive(4'b0000);
    end
    cyc(6);
  endtask

  initial begin
    reset = 1'b1;
    bus = '0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1;
    chk({31'h0, shutter_open}, 32'h1, "shutter after reset");
    rchk(`TSE_ADDR_CTRL, 32'h0);
    rchk(`TSE_ADDR_DIV, 32'h1);
    rchk(`TSE_ADDR_MUL, 32'h1);
    rchk(`TSE_ADDR_HOLD_CNT, 32'h0);
    rchk(`TSE_ADDR_SHUT_CNT, 32'h0);
    rchk(`TSE_ADDR_AUTO, 32'h000a0880);
    for (int s = 0; s < 5; s++) begin
      wr(`TSE_ADDR_CTRL, 32'(s) << 2);
      cyc(3);
      n = trig_seen;
      u_far.drive(4'b1000);
      cyc(3);
      u_far.drive(4'b0000);
      cyc(4);
      chk(32'(trig_seen - n), 32'(sense_exp[s]), "sense count");
    end
    wr(`TSE_ADDR_CTRL, 32'h0);
    // Ratio cases: div 2 mul 1, div 1 mul 2, div 3 mul 2
    for (int i = 0; i < 3; i++) begin
      wr(`TSE_ADDR_DIV, 32'(dtab[i]));
      wr(`TSE_ADDR_MUL, 32'(mtab[i]));
      n = trig_seen;
      pulses(ptab[i]);
      chk(32'(trig_seen - n), 32'h2, "scaled count");
    end
    wr(`TSE_ADDR_DIV, 32'h1);
    wr(`TSE_ADDR_MUL, 32'h1);
    #1;
    chk({31'h0, shutter_open}, 32'h1, "policy off");
    wr(`TSE_ADDR_HOLD_US, 32'h2);
    rchk(`TSE_ADDR_HOLD_CNT, 32'd20);
    rchk(`TSE_ADDR_HOLD_US_LEG, 32'h2);
    wr(`TSE_ADDR_HOLD_CNT, 32'd40);
    rchk(`TSE_ADDR_HOLD_US, 32'h4);
    wr(`TSE_ADDR_HOLD_CNT, 32'h3);
    latency(31);
    n = trig_seen;
    pulses(2);
    cyc(40);
    chk(32'(trig_seen - n), 32'h1, "drop while delayed");
    wr(`TSE_ADDR_HOLD_CNT, 32'h1);
    latency(11);
    wr(`TSE_ADDR_HOLD_CNT, 32'h0);
    latency(1);
    wr(`TSE_ADDR_SHUT_US, 32'h1);
    rchk(`TSE_ADDR_SHUT_CNT, 32'd10);
    wr(`TSE_ADDR_SHUT_CNT, 32'd30);
    rchk(`TSE_ADDR_SHUT_US, 32'h3);
    rchk(`TSE_ADDR_SHUT_US_LEG, 32'h3);
    wr(`TSE_ADDR_SHUT_CNT, 32'h2);
    wr(`TSE_ADDR_CTRL, 32'h1);
    cyc(2);
    lvl(4'b0100, 2, 1'b0);
    u_far.drive(4'b0000);
    u_far.frame_start();
    n = 0;
    #1;
    while (shutter_open === 1'b1) begin
      n++;
      tmo(n);
      @(posedge mclk);
      #1;
    end
    chk(32'(n), 32'd20, "timed length");
    wr(`TSE_ADDR_CTRL, 32'h2);
    lvl(4'b1000, 1, 1'b1);
    lvl(4'b0000, 1, 1'b0);
    wr(`TSE_ADDR_CTRL, 32'h6);
    lvl(4'b0000, 1, 1'b1);
    lvl(4'b1000, 1, 1'b0);
    wr(`TSE_ADDR_CTRL, 32'h3);
    lvl(4'b0100, 2, 1'b1);
    lvl(4'b1000, 2, 1'b1);
    lvl(4'b0010, 2, 1'b0);
    lvl(4'b0000, 1, 1'b0);
    wr(`TSE_ADDR_CTRL, 32'h83);
    lvl(4'b0001, 1, 1'b1);
    lvl(4'b0000, 1, 1'b0);
    wr(`TSE_ADDR_CTRL, 32'h183);
    lvl(4'b0000, 1, 1'b1);
    lvl(4'b0001, 1, 1'b0);
    wr(`TSE_ADDR_CTRL, 32'h603);
    lvl(4'b0100, 2, 1'b0);
    lvl(4'b0000, 2, 1'b1);
    lvl(4'b0010, 2, 1'b1);
    lvl(4'b0000, 2, 1'b0);
    wr(`TSE_ADDR_CTRL, 32'h1);
    wr(`TSE_ADDR_SHUT_CNT, 32'd100);
    wr(`TSE_ADDR_CTRL, 32'h21);
    u_far.meter(8'h10);
    cyc(2);
    rchk(`TSE_ADDR_SHUT_CNT, 32'd110);
    rchk(`TSE_ADDR_CTRL, 32'h21);
    u_far.meter(8'h80);
    cyc(2);
    rchk(`TSE_ADDR_CTRL, 32'h1);
    rchk(`TSE_ADDR_STATUS, 32'h8);
    wr(`TSE_ADDR_CTRL, 32'h41);
    u_far.meter(8'hf0);
    u_far.meter(8'hf0);
    u_far.meter(8'h80);
    cyc(2);
    rchk(`TSE_ADDR_SHUT_CNT, 32'd90);
    rchk(`TSE_ADDR_CTRL, 32'h41);
    wr(`TSE_ADDR_CTRL, 32'h1);
    u_far.meter(8'h10);
    cyc(2);
    rchk(`TSE_ADDR_SHUT_CNT, 32'd90);
    wr(`TSE_ADDR_CTRL, 32'h40);
    u_far.meter(8'h10);
    cyc(2);
    rchk(`TSE_ADDR_SHUT_CNT, 32'd90);
    wr(8'h3c, 32'hffffffff);
    rchk(8'h3c, 32'h0);
    rchk(`TSE_ADDR_CTRL, 32'h40);
    wrap_up();
  end
endmodule
